// *** sas_host_model.sv ***
`timescale 1ns/1ns
// Readout side: takes the spectrum a chosen number of cycles after it is offered
module sas_host_model (
	input wire logic clock, // System clock
	input wire logic rst, // Asynchronous reset, active high
	input wire logic ready, // Spectrum offered by the sequencer
	input wire logic [3:0] lag, // Extra cycles before taking it
	output logic spectrum_taken // One-cycle take pulse
);
	logic [3:0] wait_q;

	// Never takes unless offered; the pulse is one cycle so it cannot be seen twice
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			spectrum_taken <= 1'b0;
			wait_q <= 4'h0;
		end else begin
			spectrum_taken <= 1'b0;
			if (ready && !spectrum_taken) begin
				if (wait_q == lag) begin
					spectrum_taken <= 1'b1;
					wait_q <= 4'h0;
				end else begin
					wait_q <= wait_q + 4'h1;
				end
			end
		end
	end
endmodule : sas_host_model

// *** sas_pkg.sv ***
package sas_pkg;

	// Timebase
	localparam int CLOCK_HZ = 50_000_000;
	localparam int CYC_PER_US = CLOCK_HZ / 1_000_000;

	// Fixed busy periods, in microseconds and in clock cycles
	localparam int INITIAL_BUSY_TIME_US = 1561;
	localparam int FINAL_BUSY_TIME_US = 1553;
	localparam int INITIAL_BUSY_CYC = INITIAL_BUSY_TIME_US * CYC_PER_US;
	localparam int FINAL_BUSY_CYC = FINAL_BUSY_TIME_US * CYC_PER_US;

	// Programmable ranges
	localparam int ACQ_DELAY_MAX_TIME_US = 335_500;
	localparam int INTEG_STEP_US = 10;
	localparam int INTEG_MIN_TIME_US = 3800;
	localparam int INTEG_MAX_TIME_US = 6_000_000;
	localparam int INTEG_MIN_STEPS = INTEG_MIN_TIME_US / INTEG_STEP_US;
	localparam int INTEG_MAX_STEPS = INTEG_MAX_TIME_US / INTEG_STEP_US;
	localparam int CS_HALF_US = INTEG_STEP_US / 2;

	// Down counter width: holds the longest window in cycles
	localparam int TIMER_W = 29;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] REG_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] REG_ACQ_DELAY = 8'h08;
	localparam logic [ADDR_W-1:0] REG_INTEG = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_SS_DELAY = 8'h10;
	localparam logic [ADDR_W-1:0] REG_SS_WIDTH = 8'h14;
	localparam logic [ADDR_W-1:0] REG_CS_PERIOD = 8'h18;
	localparam logic [ADDR_W-1:0] REG_CS_LOW = 8'h1C;

	// Field positions
	localparam int CTRL_ACQUIRE_BIT = 0;
	localparam int CTRL_SRC_LSB = 1;
	localparam int CTRL_MODE_BIT = 3;
	localparam int STATUS_READY_BIT = 3;
	localparam int STATUS_ERR_BIT = 4;
	localparam int STATUS_BUSY_BIT = 5;

	typedef enum logic [1:0] {
		SRC_SOFTWARE = 2'h0,
		SRC_EXT_EDGE = 2'h1,
		SRC_EXT_LEVEL = 2'h2
	} sas_src_t;

	typedef enum logic {
		MODE_SINGLE = 1'h0,
		MODE_AVERAGE = 1'h1
	} sas_mode_t;

	// Gray along idle, initial delay, integration, final busy, transfer
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_INIT = 3'h1,
		ST_INTEG = 3'h3,
		ST_FINAL = 3'h2,
		ST_XFER = 3'h6
	} sas_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} sas_bus_t;

	typedef struct packed {
		sas_src_t src;
		logic [18:0] acq_delay;
		logic [19:0] integ;
		logic [23:0] ss_delay;
		logic [23:0] ss_width;
		logic [19:0] cs_period;
	} sas_cfg_t;

	// Values after reset
	localparam sas_src_t SRC_RST = SRC_SOFTWARE;
	localparam sas_mode_t MODE_RST = MODE_SINGLE;
	localparam logic [18:0] ACQ_DELAY_RST = 19'h00000;
	localparam logic [19:0] INTEG_RST = 20'(INTEG_MIN_STEPS);
	localparam logic [23:0] SS_DELAY_RST = 24'h000000;
	localparam logic [23:0] SS_WIDTH_RST = 24'h000000;
	localparam logic [19:0] CS_PERIOD_RST = 20'h00000;

endpackage : sas_pkg

// *** sas_sequencer.sv ***
`timescale 1ns/1ns
//Function
// - One integration per cycle; spectrum handed over before another trigger is taken.
// - After reset the acquisition mode is single spectrum.
// - Triggers come from software, external rising edge or external level.
// - Trigger source resets to software; only a host request triggers then.
// - Each trigger runs initial delay, integration, final delay, then data return.
// - Initial delay equals programmed acquisition delay plus fixed 1561 us busy.
// - Acquisition delay ranges 0 to 335,500 us in 1 us steps.
// - Integration window is 3800 us to 6 s, 10 us steps; level mode ends it when the pin falls, at most 6 s; light only then.
// - Fixed 1553 us busy after integration, then transfer and become ready.
// - Single strobe rises after its delay from trigger, stays high its width.
// - Single strobe is forced low when integration ends.
// - Continuous strobe pulses at its period from integration start, 50% duty.
// - Whole continuous periods except in level mode; there a period that cannot finish is cut at integration end.
// - Continuous period in 10 us steps; outside level mode active only when shorter than integration.
// - Continuous strobe low time lies between zero and the period.
module sas_sequencer
	import sas_pkg::*;
#(
	parameter int P_US_CYC = CYC_PER_US,
	parameter int P_INITIAL_BUSY_CYC = INITIAL_BUSY_CYC,
	parameter int P_FINAL_BUSY_CYC = FINAL_BUSY_CYC
) (
	input wire logic clock, // System clock, 50 MHz
	input wire logic rst, // Asynchronous reset, active high
	input wire sas_bus_t bus, // Register port from software
	output logic [DATA_W-1:0] rdata_q, // Read data, cycle after the read strobe
	input wire logic ext_trigger, // External trigger pin, asynchronous
	input wire logic spectrum_taken, // Readout logic has moved the spectrum out
	output logic integrating_q, // Detector collects light while high
	output logic single_strobe_q, // Single strobe pin
	output logic cont_strobe_q, // Continuous strobe pin
	output logic spectrum_ready_q, // Spectrum waits for transfer
	output logic busy_q // Acquisition cycle or transfer in progress
);

	sas_cfg_t cfg_q;
	sas_state_t state_q;
	sas_state_t state_d;
	logic ext_meta_q, ext_sync_q, ext_prev_q;
	logic lvl_mode_q, lvl_err_q;
	logic [1:0] ss_phase_q;
	logic cs_on_q, cs_hi_q;

	// Register decode
	wire wr_ctrl = bus.wr && (bus.addr == REG_CONTROL);
	wire wr_stat = bus.wr && (bus.addr == REG_STATUS);
	wire wr_acq = bus.wr && (bus.addr == REG_ACQ_DELAY);
	wire wr_integ = bus.wr && (bus.addr == REG_INTEG);
	wire wr_ssd = bus.wr && (bus.addr == REG_SS_DELAY);
	wire wr_ssw = bus.wr && (bus.addr == REG_SS_WIDTH);
	wire wr_csp = bus.wr && (bus.addr == REG_CS_PERIOD);
	wire sw_req = wr_ctrl && bus.wdata[CTRL_ACQUIRE_BIT];
	wire [1:0] src_wr = bus.wdata[CTRL_SRC_LSB +: 2];

	// Out-of-range writes are clamped so the sequencer never sees an illegal time
	wire [18:0] acq_wr = (bus.wdata > DATA_W'(ACQ_DELAY_MAX_TIME_US))
		? 19'(ACQ_DELAY_MAX_TIME_US) : bus.wdata[18:0];
	wire [19:0] integ_wr = (bus.wdata < DATA_W'(INTEG_MIN_STEPS)) ? 20'(INTEG_MIN_STEPS)
		: (bus.wdata > DATA_W'(INTEG_MAX_STEPS)) ? 20'(INTEG_MAX_STEPS)
		: bus.wdata[19:0];
	wire [19:0] csp_wr = (bus.wdata > DATA_W'(INTEG_MAX_STEPS))
		? 20'(INTEG_MAX_STEPS) : bus.wdata[19:0];
	wire src_ok = (src_wr == SRC_SOFTWARE) || (src_wr == SRC_EXT_EDGE)
		|| (src_wr == SRC_EXT_LEVEL);

	// Configuration registers; a reserved source code leaves the source unchanged
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cfg_q <= '{src: SRC_RST, acq_delay: ACQ_DELAY_RST, integ: INTEG_RST,
				ss_delay: SS_DELAY_RST, ss_width: SS_WIDTH_RST,
				cs_period: CS_PERIOD_RST};
		end else begin
			if (wr_ctrl && src_ok) cfg_q.src <= sas_src_t'(src_wr);
			if (wr_acq) cfg_q.acq_delay <= acq_wr;
			if (wr_integ) cfg_q.integ <= integ_wr;
			if (wr_ssd) cfg_q.ss_delay <= bus.wdata[23:0];
			if (wr_ssw) cfg_q.ss_width <= bus.wdata[23:0];
			if (wr_csp) cfg_q.cs_period <= csp_wr;
		end
	end

	// Trigger pin synchroniser; only the second and third stages feed the edge logic
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ext_meta_q <= 1'b0;
			ext_sync_q <= 1'b0;
			ext_prev_q <= 1'b0;
		end else begin
			ext_meta_q <= ext_trigger;
			ext_sync_q <= ext_meta_q;
			ext_prev_q <= ext_sync_q;
		end
	end

	wire ext_rise = ext_sync_q && !ext_prev_q;
	wire ext_fall = !ext_sync_q && ext_prev_q;

	// Phase timing in cycles
	wire [TIMER_W-1:0] init_cyc = TIMER_W'(cfg_q.acq_delay * P_US_CYC + P_INITIAL_BUSY_CYC);
	wire [TIMER_W-1:0] integ_cyc = TIMER_W'(cfg_q.integ * INTEG_STEP_US * P_US_CYC);
	wire [TIMER_W-1:0] integ_max_cyc = TIMER_W'(INTEG_MAX_TIME_US * P_US_CYC);
	wire [TIMER_W-1:0] lvl_err_cyc = TIMER_W'((INTEG_MAX_TIME_US - INTEG_MIN_TIME_US) * P_US_CYC);
	wire [TIMER_W-1:0] final_cyc = TIMER_W'(P_FINAL_BUSY_CYC);
	wire [TIMER_W-1:0] cs_per_cyc = TIMER_W'(cfg_q.cs_period * INTEG_STEP_US * P_US_CYC);
	wire [TIMER_W-1:0] cs_half_cyc = TIMER_W'(cfg_q.cs_period * CS_HALF_US * P_US_CYC);
	wire [TIMER_W-1:0] ssd_cyc = TIMER_W'(cfg_q.ss_delay * P_US_CYC);
	wire [TIMER_W-1:0] ssw_cyc = TIMER_W'(cfg_q.ss_width * P_US_CYC);

	logic ph_done, ss_done, cs_done;
	logic [TIMER_W-1:0] ph_remain;

	// Sequence events; triggers outside idle fall on the floor
	wire idle = (state_q == ST_IDLE);
	wire trig_evt = idle && (((cfg_q.src == SRC_SOFTWARE) && sw_req)
		|| ((cfg_q.src != SRC_SOFTWARE) && ext_rise));
	wire init_done = (state_q == ST_INIT) && ph_done;
	wire integ_end = (state_q == ST_INTEG)
		&& (ph_done || (lvl_mode_q && ext_fall));
	wire final_done = (state_q == ST_FINAL) && ph_done;
	wire taken = (state_q == ST_XFER) && spectrum_taken;
	wire lvl_short = integ_end && lvl_mode_q && (ph_remain > lvl_err_cyc);

	// Level mode runs on the pin width, capped at the longest window
	wire ph_load = trig_evt || init_done || integ_end;
	wire [TIMER_W-1:0] ph_value = trig_evt ? init_cyc
		: init_done ? (lvl_mode_q ? integ_max_cyc : integ_cyc) : final_cyc;

	// Next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: if (trig_evt) state_d = ST_INIT;
			ST_INIT: if (init_done) state_d = ST_INTEG;
			ST_INTEG: if (integ_end) state_d = ST_FINAL;
			ST_FINAL: if (final_done) state_d = ST_XFER;
			ST_XFER: if (taken) state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	sas_timer #(.W(TIMER_W)) u_phase (
		.clock(clock),
		.rst(rst),
		.load(ph_load),
		.value(ph_value),
		.done(ph_done),
		.remain(ph_remain)
	);

	// Sequencer state, level latch and the sticky short-pulse error; set wins
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			lvl_mode_q <= 1'b0;
			lvl_err_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (trig_evt) lvl_mode_q <= (cfg_q.src == SRC_EXT_LEVEL);
			lvl_err_q <= lvl_short || (lvl_err_q && !(wr_stat && bus.wdata[STATUS_ERR_BIT]));
		end
	end

	// Single strobe: 0 idle, 1 counting delay, 2 high
	wire ss_rise = (ss_phase_q == 2'h1) && ss_done && (cfg_q.ss_width != 24'h000000);
	wire ss_stop = integ_end || ((ss_phase_q != 2'h0) && ss_done && !ss_rise);
	wire ss_load = trig_evt || ss_rise;

	sas_timer #(.W(TIMER_W)) u_single (
		.clock(clock),
		.rst(rst),
		.load(ss_load),
		.value(trig_evt ? ssd_cyc : ssw_cyc),
		.done(ss_done),
		.remain()
	);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ss_phase_q <= 2'h0;
			single_strobe_q <= 1'b0;
		end else if (trig_evt) begin
			ss_phase_q <= 2'h1;
		end else if (ss_stop) begin
			ss_phase_q <= 2'h0;
			single_strobe_q <= 1'b0;
		end else if (ss_rise) begin
			ss_phase_q <= 2'h2;
			single_strobe_q <= 1'b1;
		end
	end

	// Continuous strobe; edge mode checks a whole period still fits, level mode
	// cannot know the end in advance and is simply cut at integration end
	wire cs_enable = (cfg_q.cs_period != 20'h00000)
		&& (lvl_mode_q || (cfg_q.cs_period < cfg_q.integ));
	wire cs_period_end = cs_on_q && !cs_hi_q && cs_done;
	wire cs_start = (init_done && cs_enable) || (cs_period_end && !integ_end
		&& (lvl_mode_q || (ph_remain > cs_per_cyc)));
	wire cs_fall = cs_on_q && cs_hi_q && cs_done;

	sas_timer #(.W(TIMER_W)) u_cont (
		.clock(clock),
		.rst(rst),
		.load(cs_start || cs_fall),
		.value(cs_half_cyc),
		.done(cs_done),
		.remain()
	);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cs_on_q <= 1'b0;
			cs_hi_q <= 1'b0;
		end else if (integ_end || (cs_period_end && !cs_start)) begin
			cs_on_q <= 1'b0;
			cs_hi_q <= 1'b0;
		end else if (cs_start) begin
			cs_on_q <= 1'b1;
			cs_hi_q <= 1'b1;
		end else if (cs_fall) begin
			cs_hi_q <= 1'b0;
		end
	end

	// Read mux; unmapped addresses read zero
	wire [DATA_W-1:0] ctrl_rd = DATA_W'({MODE_RST, cfg_q.src, 1'b0});
	wire [DATA_W-1:0] stat_rd = DATA_W'({busy_q, lvl_err_q, spectrum_ready_q, state_q});
	wire [DATA_W-1:0] cs_low_rd = DATA_W'(cfg_q.cs_period * CS_HALF_US);
	wire [DATA_W-1:0] rd_mux = (bus.addr == REG_CONTROL) ? ctrl_rd
		: (bus.addr == REG_STATUS) ? stat_rd
		: (bus.addr == REG_ACQ_DELAY) ? DATA_W'(cfg_q.acq_delay)
		: (bus.addr == REG_INTEG) ? DATA_W'(cfg_q.integ)
		: (bus.addr == REG_SS_DELAY) ? DATA_W'(cfg_q.ss_delay)
		: (bus.addr == REG_SS_WIDTH) ? DATA_W'(cfg_q.ss_width)
		: (bus.addr == REG_CS_PERIOD) ? DATA_W'(cfg_q.cs_period)
		: (bus.addr == REG_CS_LOW) ? cs_low_rd : '0;

	// Outputs all leave from flops; read data stands one cycle only
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdata_q <= '0;
			integrating_q <= 1'b0;
			cont_strobe_q <= 1'b0;
			spectrum_ready_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			rdata_q <= bus.rd ? rd_mux : '0;
			integrating_q <= (state_d == ST_INTEG);
			cont_strobe_q <= (cs_start || (cs_hi_q && !cs_fall)) && !integ_end;
			spectrum_ready_q <= (state_d == ST_XFER);
			busy_q <= (state_d != ST_IDLE);
		end
	end

	// Helper counters for the checks below
	logic [TIMER_W-1:0] dwell_q, since_trig_q, cs_hi_cnt_q;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dwell_q <= '0;
			since_trig_q <= '0;
			cs_hi_cnt_q <= '0;
		end else begin
			dwell_q <= (state_d != state_q) ? '0 : dwell_q + TIMER_W'(1);
			since_trig_q <= trig_evt ? '0 : since_trig_q + TIMER_W'(1);
			cs_hi_cnt_q <= cont_strobe_q ? cs_hi_cnt_q + TIMER_W'(1) : '0;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_reset_defaults: assert property ($past(rst) |-> (cfg_q.src == SRC_SOFTWARE)
		&& (state_q == ST_IDLE) && (ctrl_rd[CTRL_MODE_BIT] == MODE_SINGLE))
		else $error("defaults after reset wrong");
	a_enter_init: assert property ((state_q == ST_INIT) && ($past(state_q) != ST_INIT)
		|-> $past(idle && (sw_req || ext_rise)))
		else $error("initial delay entered without trigger");
	// A request taken while busy would restart the trigger counter
	a_busy_ignores: assert property (!idle && sw_req |=> (since_trig_q != '0))
		else $error("trigger accepted while busy");
	a_init_length: assert property ((state_q == ST_INIT) && (state_d == ST_INTEG)
		|-> (dwell_q == init_cyc - TIMER_W'(1)))
		else $error("initial delay length wrong");
	a_integ_length: assert property ($fell(integrating_q) && !lvl_mode_q
		|-> ($past(dwell_q) == integ_cyc - TIMER_W'(1)))
		else $error("integration length wrong");
	a_final_length: assert property ((state_q == ST_FINAL) && (state_d == ST_XFER)
		|-> (dwell_q == final_cyc - TIMER_W'(1)))
		else $error("final busy length wrong");
	a_acq_clamp: assert property (cfg_q.acq_delay <= 19'(ACQ_DELAY_MAX_TIME_US))
		else $error("acquisition delay out of range");
	a_ss_delay: assert property ($rose(single_strobe_q) && (cfg_q.ss_delay != 24'h000000)
		|-> (since_trig_q == ssd_cyc))
		else $error("single strobe rose at wrong time");
	a_strobes_low: assert property ($fell(integrating_q)
		|-> !single_strobe_q && !cont_strobe_q)
		else $error("strobe high after integration");
	a_cs_half_high: assert property ($fell(cont_strobe_q) && integrating_q
		|-> ($past(cs_hi_cnt_q) == cs_half_cyc - TIMER_W'(1)))
		else $error("continuous strobe duty wrong");
	a_cs_full_period: assert property ($rose(cont_strobe_q) && !lvl_mode_q
		|-> (ph_remain >= cs_per_cyc))
		else $error("partial continuous period started");
	a_cs_inside: assert property (cont_strobe_q |-> integrating_q
		&& (lvl_mode_q || (cfg_q.cs_period < cfg_q.integ)))
		else $error("continuous strobe outside window");
	a_cs_low_read: assert property (bus.rd && (bus.addr == REG_CS_LOW)
		|=> (rdata_q <= DATA_W'(cfg_q.cs_period) * DATA_W'(INTEG_STEP_US)))
		else $error("continuous low time above period");

	c_full_cycle: cover property ((state_q == ST_XFER) && spectrum_taken);
	c_cont_pulse: cover property ($fell(cont_strobe_q) && integrating_q);
	c_single_pulse: cover property ($fell(single_strobe_q));
	c_level_error: cover property ($rose(lvl_err_q));

endmodule : sas_sequencer

// *** sas_timer.sv ***
`timescale 1ns/1ns
module sas_timer
	import sas_pkg::*;
#(
	parameter int W = TIMER_W
) (
	input wire logic clock, // System clock
	input wire logic rst, // Asynchronous reset, active high
	input wire logic load, // Start a new count
	input wire logic [W-1:0] value, // Cycles to run, zero acts as one
	output logic done, // High in the last cycle of the count
	output logic [W-1:0] remain // Cycles left, current one included
);

	logic [W-1:0] cnt_q;
	logic run_q;

	// Done is decoded so the caller can act on the very last cycle
	assign done = run_q && (cnt_q <= W'(1));
	assign remain = cnt_q;

	// Load beats expiry so back to back phases never lose a cycle
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
			run_q <= 1'b0;
		end else if (load) begin
			cnt_q <= value;
			run_q <= 1'b1;
		end else if (done) begin
			cnt_q <= '0;
			run_q <= 1'b0;
		end else if (run_q) begin
			cnt_q <= cnt_q - W'(1);
		end
	end

endmodule : sas_timer

// *** testbench.sv ***
`timescale 1ns/1ns
module testbench
	import sas_pkg::*;
;
	localparam logic [31:0] SK = 32'hFFFFFFFF;
	localparam int PU = 2;
	localparam int IB = 20;
	localparam int FB = 16;
	localparam int IC = INTEG_MIN_STEPS * INTEG_STEP_US * PU;
	localparam int CP = 35 * INTEG_STEP_US * PU;
	logic clock;
	logic rst;
	sas_bus_t bus;
	logic ext_trigger;
	logic spectrum_taken;
	logic [DATA_W-1:0] rdata_q;
	logic integrating_q, single_strobe_q, cont_strobe_q, spectrum_ready_q, busy_q;
	logic [3:0] lag;
	logic [31:0] seed;
	logic [31:0] q_rd[$];
	logic [31:0] q_tm[$];
	logic [31:0] m[10];
	logic [31:0] e[10];
	logic [31:0] cnt;
	logic rd_seen, int_p, ss_p, cs_p, rdy_p;
	int n_mismatch, cmp_count, d;

	// Short busy periods keep the run near 23k cycles
	sas_sequencer #(.P_US_CYC(PU), .P_INITIAL_BUSY_CYC(IB), .P_FINAL_BUSY_CYC(FB)) uut (
		.clock(clock), .rst(rst), .bus(bus), .rdata_q(rdata_q), .ext_trigger(ext_trigger),
		.spectrum_taken(spectrum_taken), .integrating_q(integrating_q),
		.single_strobe_q(single_strobe_q), .cont_strobe_q(cont_strobe_q),
		.spectrum_ready_q(spectrum_ready_q), .busy_q(busy_q));
	sas_host_model host (.clock(clock), .rst(rst), .ready(spectrum_ready_q), .lag(lag),
		.spectrum_taken(spectrum_taken));

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wrap_up();
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up

	// Bus cycles; the leading edge keeps strobes from being set twice in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		bus.addr <= a;
		bus.wdata <= v;
		bus.wr <= 1'b1;
		@(posedge clock);
		bus.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		q_rd.push_back(v);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clock);
		bus.rd <= 1'b0;
	endtask : rd

	task automatic ext(input int n);
		@(posedge clock);
		ext_trigger <= 1'b1;
		repeat (n) @(posedge clock);
		ext_trigger <= 1'b0;
	endtask : ext

	task automatic arm();
		foreach (e[i]) q_tm.push_back(e[i]);
	endtask : arm

	task automatic wait_idle();
		int k = 0;
		// Busy shows only an edge after the request, so let it rise before polling
		repeat (2) @(posedge clock);
		chk({31'h0, busy_q}, 32'h1);
		while (busy_q !== 1'b0 && k < 20000) begin
			@(posedge clock);
			k++;
		end
		chk({31'h0, busy_q}, 32'h0);
	endtask : wait_idle

	// Read data stands only in the cycle after the strobe
	always @(posedge clock) begin
		if (rd_seen) chk(rdata_q, q_rd.pop_front());
		rd_seen = bus.rd;
	end

	// Phase lengths and strobe activity measured from the cycle busy rises
	always @(posedge clock) begin
		if (!busy_q) begin
			cnt = 0;
			foreach (m[i]) m[i] = 0;
		end else begin
			if (integrating_q && !int_p) begin
				m[0]++;
				m[1] = cnt;
				m[9] = {31'h0, cont_strobe_q};
			end
			if (integrating_q) m[2]++;
			if (!integrating_q && m[2] != 0 && !spectrum_ready_q) m[3]++;
			if (single_strobe_q && !ss_p) m[4] = cnt;
			if (single_strobe_q) m[5]++;
			if (cont_strobe_q && !cs_p) m[6]++;
			if (cont_strobe_q) m[7]++;
			if (cont_strobe_q && !integrating_q) m[8]++;
			if (spectrum_ready_q && !rdy_p) begin
				for (int i = 0; i < 10; i++) begin
					e[i] = q_tm.pop_front();
					if (e[i] !== SK) chk(m[i], e[i]);
				end
			end
			cnt++;
		end
		int_p = integrating_q;
		ss_p = single_strobe_q;
		cs_p = cont_strobe_q;
		rdy_p = spectrum_ready_q;
	end

	initial begin
		repeat (60000) @(posedge clock);
		n_mismatch++;
		wrap_up();
	end

	initial begin
		rst = 1'b1;
		bus = '0;
		ext_trigger = 1'b0;
		lag = 4'h0;
		seed = 32'h00008827;
		n_mismatch = 0;
		cmp_count = 0;
		rd_seen = 1'b0;
		cnt = 0;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		// Power-on configuration, unmapped place reads zero
		rd(REG_CONTROL, 32'h0);
		rd(REG_STATUS, 32'h0);
		rd(REG_INTEG, 32'h0000017C);
		rd(REG_CS_PERIOD, 32'h0);
		rd(8'h20, 32'h0);
		// The pin must not start a cycle while software triggering is selected
		ext(4);
		repeat (6) @(posedge clock);
		rd(REG_STATUS, 32'h0);
		wr(REG_ACQ_DELAY, 32'h000FFFFF);
		rd(REG_ACQ_DELAY, 32'h00051E8C);
		wr(REG_INTEG, 32'h0000000A);
		rd(REG_INTEG, 32'h0000017C);
		// Software run, random delay, whole strobe periods, a stray request mid-run
		seed = xs(seed);
		d = int'(seed[4:0]);
		lag = seed[11:8];
		wr(REG_ACQ_DELAY, 32'(d));
		wr(REG_SS_DELAY, 32'h0000000A);
		wr(REG_SS_WIDTH, 32'h0000001E);
		wr(REG_CS_PERIOD, 32'h00000023);
		rd(REG_CS_LOW, 32'h000000AF);
		e = '{1, d * PU + IB, IC, FB, 10 * PU, 30 * PU, IC / CP, (IC / CP) * (CP / 2), 0, 1};
		arm();
		wr(REG_CONTROL, 32'h00000001);
		repeat (5) @(posedge clock);
		wr(REG_CONTROL, 32'h00000001);
		rd(REG_STATUS, 32'h00000021);
		wait_idle();
		repeat (4) @(posedge clock);
		rd(REG_STATUS, 32'h0);
		// Strobe cut by integration end; period equal to window stays off
		seed = xs(seed);
		lag = seed[3:0];
		wr(REG_ACQ_DELAY, 32'h0);
		wr(REG_SS_DELAY, 32'h00000ED8);
		wr(REG_SS_WIDTH, 32'h00000064);
		wr(REG_CS_PERIOD, 32'h0000017C);
		e = '{1, IB, IC, FB, 3800 * PU, IB + IC - 3800 * PU, 0, 0, 0, 0};
		arm();
		wr(REG_CONTROL, 32'h00000001);
		wait_idle();
		// Edge trigger, zero strobe width
		wr(REG_CONTROL, 32'h00000002);
		rd(REG_CONTROL, 32'h00000002);
		// Reserved source code must leave the edge source in place
		wr(REG_CONTROL, 32'h00000006);
		rd(REG_CONTROL, 32'h00000002);
		wr(REG_ACQ_DELAY, 32'h00000005);
		wr(REG_SS_WIDTH, 32'h0);
		wr(REG_CS_PERIOD, 32'h0);
		e = '{1, 5 * PU + IB, IC, FB, 0, 0, 0, 0, 0, 0};
		arm();
		ext(2);
		repeat (6) @(posedge clock);
		wait_idle();
		// Level trigger too short: sticky error, cleared by writing one
		wr(REG_CONTROL, 32'h00000004);
		wr(REG_ACQ_DELAY, 32'h0);
		e = '{1, IB, SK, FB, 0, 0, 0, 0, 0, 0};
		arm();
		ext(100);
		wait_idle();
		rd(REG_STATUS, 32'h00000010);
		wr(REG_STATUS, 32'h00000010);
		rd(REG_STATUS, 32'h0);
		chk(32'(q_tm.size()), 32'h0);
		repeat (3) @(posedge clock);
		wrap_up();
	end
endmodule : testbench
